// file: core/aprx_cfg.svh
`ifndef APRX_CFG_SVH
`define APRX_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define APRX_ADDR_TX_LANE8 8'h25
`define APRX_ADDR_RX_CAPTURE 8'h26
`define APRX_ADDR_RX_PINSEL 8'h27
`define APRX_ADDR_STATUS 8'h30

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define APRX_RST_TX_SLOT 5'h07
`define APRX_RST_TX_SRC 1'h0
`define APRX_RST_RX_CAPTURE 8'h00
`define APRX_RST_RX_PINSEL 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define APRX_TX_SRC_BIT 5
`define APRX_RX_EDGE_BIT 7
`define APRX_RX_INT_FRAME_BIT 6
`define APRX_RX_INT_BITCLK_BIT 5
`define APRX_STATUS_BUSY_BIT 0
`define APRX_RIGHT_HALF_BASE 5'h10

`endif

// file: core/aprx_pkg.sv
package aprx_pkg;

  // frame formats
  typedef enum logic [1:0]
  {
    APRX_FMT_TDM = 2'h0,
    APRX_FMT_I2S = 2'h1,
    APRX_FMT_LJ = 2'h2
  } aprx_fmt_t;

  // slot walker states, gray along wait -> lead -> active
  typedef enum logic [1:0]
  {
    APRX_WAIT_FRAME = 2'h0,
    APRX_LEAD = 2'h1,
    APRX_ACTIVE = 2'h3
  } aprx_walk_t;

  // configuration word handed to the link domain
  typedef struct packed {
    logic tx_src;
    logic [4:0] tx_slot;
    logic [7:0] rx_capture;
    logic [7:0] rx_pinsel;
    logic bitclk_pol;
    logic ctrl_mode;
    aprx_fmt_t fmt;
    logic [5:0] slot_width;
  } aprx_word_t;

  // system clock domain state
  typedef struct packed {
    logic tx_src;
    logic [4:0] tx_slot;
    logic [7:0] rx_capture;
    logic [7:0] rx_pinsel;
    logic [7:0] rd_data;
    logic req;
    aprx_word_t hold;
  } aprx_sys_t;

  // slot position tracker
  typedef struct packed {
    aprx_walk_t st;
    logic [5:0] wait_cnt;
    logic [4:0] slot;
    logic [5:0] bit_cnt;
  } aprx_pos_t;

  // link clock domain state
  typedef struct packed {
    aprx_word_t cfg;
    logic ack;
    logic bc_prev;
    logic fs_prev;
    aprx_pos_t rx;
    aprx_pos_t tx;
    logic rx_valid;
    logic [7:0] rx_bits;
    logic [4:0] rx_slot;
    logic [5:0] rx_bit;
    logic tx_data;
    logic tx_oe;
  } aprx_lnk_t;

endpackage : aprx_pkg

// file: core/aprx_sync.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// two-flop synchroniser, one stage pair per bit
// ----------------------------------------------------------------------
module aprx_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] st1;
    logic [WIDTH-1:0] st2;
  } aprx_sync_t;

  aprx_sync_t s;
  aprx_sync_t next_s;

  // first stage feeds only the second
  always_comb
  begin
    next_s = s;
    next_s.st1 = d_i;
    next_s.st2 = s.st1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign q_o = s.st2;

endmodule : aprx_sync

// file: core/aprx_top.sv
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "aprx_cfg.svh"
// ----------------------------------------------------------------------
// receive capture and lane 8 slot configuration of the audio serial port
// ----------------------------------------------------------------------
module aprx_top
  import aprx_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // settings owned by other registers
  input wire logic bitclk_polarity_cfg_i,
  input wire logic ctrl_mode_i,
  input wire logic [1:0] fmt_i,
  input wire logic [5:0] slot_width_i,
  // link side
  input wire logic link_clk_i,
  input wire logic ext_bitclk_i,
  input wire logic int_bitclk_i,
  input wire logic ext_frame_i,
  input wire logic int_frame_i,
  input wire logic primary_data_in_i,
  input wire logic secondary_data_in_i,
  input wire logic shared_link_data_i,
  output logic tx_lane8_data_o,
  output logic tx_lane8_oe_o,
  output logic rx_valid_o,
  output logic [7:0] rx_lane_bits_o,
  output logic [4:0] rx_slot_o,
  output logic [5:0] rx_bit_o
);

  aprx_sys_t s;
  aprx_sys_t next_s;
  aprx_lnk_t l;
  aprx_lnk_t next_l;
  logic lnk_reset;
  logic ack_sync;
  logic req_sync;
  logic [5:0] pins;
  aprx_word_t cur_word;

  // --------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------
  // link reset follows the system reset, so the link clock must run
  // during reset for the link side to clear
  aprx_sync #(.WIDTH(1)) u_rst_sync
  (
    .clk_i(link_clk_i),
    .reset_i(1'b0),
    .d_i(reset_i),
    .q_o(lnk_reset)
  );

  aprx_sync #(.WIDTH(1)) u_req_sync
  (
    .clk_i(link_clk_i),
    .reset_i(lnk_reset),
    .d_i(s.req),
    .q_o(req_sync)
  );

  aprx_sync #(.WIDTH(1)) u_ack_sync
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(l.ack),
    .q_o(ack_sync)
  );

  // all link input pins but shared_link_data_i share one delay so their edges stay aligned
  aprx_sync #(.WIDTH(6)) u_pin_sync
  (
    .clk_i(link_clk_i),
    .reset_i(lnk_reset),
    .d_i({secondary_data_in_i, primary_data_in_i, int_frame_i,
      ext_frame_i, int_bitclk_i, ext_bitclk_i}),
    .q_o(pins)
  );

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // step one bit along the frame; slot wraps modulo 32
  function automatic aprx_pos_t step_pos(input aprx_pos_t p,
                                         input logic [5:0] width);
    aprx_pos_t r;
    r = p;
    if (p.bit_cnt >= width - 6'h01)
    begin
      r.bit_cnt = 6'h00;
      r.slot = p.slot + 5'h01;
    end
    else
    begin
      r.bit_cnt = p.bit_cnt + 6'h01;
    end
    return r;
  endfunction : step_pos

  // restart at a half-frame edge, then wait out the lead bits
  function automatic aprx_pos_t walk_pos(input aprx_pos_t p,
                                         input logic edge_seen,
                                         input logic [4:0] base,
                                         input logic [5:0] lead,
                                         input logic [5:0] width);
    aprx_pos_t r;
    r = p;
    if (edge_seen)
    begin
      r.st = APRX_LEAD;
      r.wait_cnt = lead;
      r.slot = base;
      r.bit_cnt = 6'h00;
    end
    if (r.st == APRX_LEAD && r.wait_cnt == 6'h00)
    begin
      r.st = APRX_ACTIVE;
    end
    else if (r.st == APRX_LEAD)
    begin
      r.wait_cnt = r.wait_cnt - 6'h01;
    end
    return r;
  endfunction : walk_pos

  // --------------------------------------------------------------------
  // register file, system clock
  // --------------------------------------------------------------------
  always_comb
  begin
    cur_word.tx_src = s.tx_src;
    cur_word.tx_slot = s.tx_slot;
    cur_word.rx_capture = s.rx_capture;
    cur_word.rx_pinsel = s.rx_pinsel;
    cur_word.bitclk_pol = bitclk_polarity_cfg_i;
    cur_word.ctrl_mode = ctrl_mode_i;
    cur_word.fmt = aprx_fmt_t'(fmt_i);
    cur_word.slot_width = slot_width_i;
  end

  // writes and reads; read data stands for the one cycle after rd_i
  always_comb
  begin
    next_s = s;
    next_s.rd_data = 8'h00;
    if (wr_i)
    begin
      unique case (addr_i)
        `APRX_ADDR_TX_LANE8:
        begin
          next_s.tx_src = wr_data_i[`APRX_TX_SRC_BIT];
          next_s.tx_slot = wr_data_i[4:0];
          // top two bits are not stored at all
        end
        `APRX_ADDR_RX_CAPTURE:
        begin
          next_s.rx_capture = wr_data_i;
        end
        `APRX_ADDR_RX_PINSEL:
        begin
          next_s.rx_pinsel = wr_data_i;
        end
        default:
        begin
          next_s.rx_pinsel = s.rx_pinsel;
        end
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        `APRX_ADDR_TX_LANE8:
        begin
          next_s.rd_data = {2'h0, s.tx_src, s.tx_slot};
        end
        `APRX_ADDR_RX_CAPTURE:
        begin
          next_s.rd_data = s.rx_capture;
        end
        `APRX_ADDR_RX_PINSEL:
        begin
          next_s.rd_data = s.rx_pinsel;
        end
        `APRX_ADDR_STATUS:
        begin
          next_s.rd_data[`APRX_STATUS_BUSY_BIT] = s.req ^ ack_sync;
        end
        default:
        begin
          next_s.rd_data = 8'h00;
        end
      endcase
    end
    // refresh the link copy whenever the last hand-over is acknowledged;
    // hold stays still while a request is open
    if (ack_sync == s.req)
    begin
      next_s.hold = cur_word;
      next_s.req = ~s.req;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s <= '0;
      s.tx_slot <= `APRX_RST_TX_SLOT;
      s.tx_src <= `APRX_RST_TX_SRC;
      s.rx_capture <= `APRX_RST_RX_CAPTURE;
      s.rx_pinsel <= `APRX_RST_RX_PINSEL;
      s.hold.tx_slot <= `APRX_RST_TX_SLOT;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rd_data_o = s.rd_data;

  // --------------------------------------------------------------------
  // link logic, link clock
  // --------------------------------------------------------------------
  always_comb
  begin
    logic use_int_bc;
    logic use_int_fs;
    logic bc;
    logic fs;
    logic rise;
    logic fall;
    logic cap;
    logic launch;
    logic fs_up;
    logic fs_down;
    logic lead_edge;
    logic other_edge;
    logic half_frame;
    logic [4:0] base;
    logic [5:0] std_lead;
    logic [5:0] rx_lead;
    use_int_bc = 1'b0;
    use_int_fs = 1'b0;
    bc = 1'b0;
    fs = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    cap = 1'b0;
    launch = 1'b0;
    fs_up = 1'b0;
    fs_down = 1'b0;
    lead_edge = 1'b0;
    other_edge = 1'b0;
    half_frame = 1'b0;
    base = 5'h00;
    std_lead = 6'h00;
    rx_lead = 6'h00;
    next_l = l;
    next_l.rx_valid = 1'b0;
    // take a new configuration once per hand-over
    if (req_sync != l.ack)
    begin
      next_l.cfg = s.hold;
      next_l.ack = req_sync;
    end
    // clock and frame choice only apply in controller mode
    use_int_bc = l.cfg.ctrl_mode &
      l.cfg.rx_capture[`APRX_RX_INT_BITCLK_BIT];
    use_int_fs = l.cfg.ctrl_mode &
      l.cfg.rx_capture[`APRX_RX_INT_FRAME_BIT];
    bc = use_int_bc ? pins[1] : pins[0];
    fs = use_int_fs ? pins[3] : pins[2];
    rise = bc & ~l.bc_prev;
    fall = ~bc & l.bc_prev;
    next_l.bc_prev = bc;
    // default edge is rising for polarity 0; the edge bit flips it
    cap = (l.cfg.bitclk_pol ^ l.cfg.rx_capture[`APRX_RX_EDGE_BIT]) ?
      fall : rise;
    launch = l.cfg.bitclk_pol ? rise : fall;
    half_frame = (l.cfg.fmt != APRX_FMT_TDM);
    std_lead = (l.cfg.fmt == APRX_FMT_I2S) ? 6'h01 : 6'h00;
    rx_lead = std_lead + {1'b0, l.cfg.rx_capture[4:0]};
    if (cap)
    begin
      fs_up = fs & ~l.fs_prev;
      fs_down = ~fs & l.fs_prev;
      next_l.fs_prev = fs;
      // i2s opens the left half on a falling frame edge
      lead_edge = (l.cfg.fmt == APRX_FMT_I2S) ? fs_down : fs_up;
      other_edge = half_frame &
        ((l.cfg.fmt == APRX_FMT_I2S) ? fs_up : fs_down);
      // right half counts on from slot 16
      base = other_edge ? `APRX_RIGHT_HALF_BASE : 5'h00;
      // offset moves slot 0 of both halves
      next_l.rx = walk_pos(l.rx, lead_edge | other_edge, base, rx_lead,
        l.cfg.slot_width);
      next_l.tx = walk_pos(l.tx, lead_edge | other_edge, base, std_lead,
        l.cfg.slot_width);
      if (next_l.rx.st == APRX_ACTIVE && next_l.rx.wait_cnt == 6'h00 &&
          !(l.rx.st == APRX_LEAD && next_l.rx.st == APRX_LEAD))
      begin
        next_l.rx_valid = 1'b1;
        next_l.rx_slot = next_l.rx.slot;
        next_l.rx_bit = next_l.rx.bit_cnt;
        for (int k = 0; k < 8; k++)
        begin
          next_l.rx_bits[k] = l.cfg.rx_pinsel[k] ?
            pins[5] : pins[4];
        end
        next_l.rx = step_pos(next_l.rx, l.cfg.slot_width);
      end
    end
    // lane 8 changes on the launch edge so it is settled for capture
    if (launch)
    begin
      next_l.tx_data = shared_link_data_i;
      next_l.tx_oe = l.cfg.tx_src & (next_l.tx.st == APRX_ACTIVE) &
        (next_l.tx.slot == l.cfg.tx_slot);
      // step from a restart taken on this same edge, which happens when
      // the receive edge bit puts capture on the launch edge
      if (next_l.tx.st == APRX_ACTIVE)
      begin
        next_l.tx = step_pos(next_l.tx, l.cfg.slot_width);
      end
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    if (lnk_reset)
    begin
      l <= '0;
      l.cfg.tx_slot <= `APRX_RST_TX_SLOT;
      l.cfg.rx_pinsel <= `APRX_RST_RX_PINSEL;
    end
    else
    begin
      l <= next_l;
    end
  end

  // --------------------------------------------------------------------
  // outputs, all from flip-flops
  // --------------------------------------------------------------------
  assign tx_lane8_data_o = l.tx_data;
  assign tx_lane8_oe_o = l.tx_oe;
  assign rx_valid_o = l.rx_valid;
  assign rx_lane_bits_o = l.rx_bits;
  assign rx_slot_o = l.rx_slot;
  assign rx_bit_o = l.rx_bit;

endmodule : aprx_top

// file: testbench/aprx_far_host.sv
`timescale 1ns/100ps
// ----------------
// far-side frame source, 48 bits a frame
// ----------------
module aprx_far_host
(
  input wire logic en_i,
  input wire logic i2s_i,
  output logic bitclk_o,
  output logic frame_o,
  output logic pri_o,
  output logic sec_o
);
  int n = 0;
  // primary data is 1 around the rising edge and 0 around the falling edge, secondary the reverse,
  // so the captured value shows which edge sampled it; the clock
  // stands still while disabled but the data keeps toggling
  initial
  begin
    bitclk_o = 1'b0;
    frame_o = 1'b0;
    pri_o = 1'b0;
    sec_o = 1'b1;
    forever
    begin
      bitclk_o = en_i;
      #50;
      pri_o = 1'b0;
      sec_o = 1'b1;
      #50;
      bitclk_o = 1'b0;
      #50;
      pri_o = 1'b1;
      sec_o = 1'b0;
      if (en_i)
      begin
        n = (n + 1) % 48;
        frame_o = i2s_i ? (n >= 24) : (n == 0);
      end
      #50;
    end
  end
endmodule : aprx_far_host

// file: testbench/aprx_top_assertions.sv
`timescale 1ns/100ps
// ----------------
// port-level checks
// ----------------
module aprx_chk
  import aprx_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [5:0] slot_width_i,
  input wire logic link_clk_i,
  input wire logic shared_link_data_i,
  input wire logic tx_lane8_data_o,
  input wire logic tx_lane8_oe_o,
  input wire logic rx_valid_o,
  input wire logic [7:0] rx_lane_bits_o,
  input wire logic [5:0] rx_bit_o
);
  // shadow registers; calm counts clocks since the last write, because
  // the link side only sees a new setting after the crossing settles
  logic [5:0] sh_tx;
  logic [7:0] sh_cap;
  logic [7:0] sh_sel;
  logic [3:0] calm;
  wire quiet = (calm == 4'hF);
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sh_tx <= 6'h07;
      sh_cap <= 8'h00;
      sh_sel <= 8'h00;
      calm <= 4'h0;
    end
    else
    begin
      if (wr_i && addr_i == 8'h25)
        sh_tx <= wr_data_i[5:0];
      if (wr_i && addr_i == 8'h26)
        sh_cap <= wr_data_i;
      if (wr_i && addr_i == 8'h27)
        sh_sel <= wr_data_i;
      if (wr_i)
        calm <= 4'h0;
      else if (!quiet)
        calm <= calm + 4'h1;
    end
  end
  // a read request at one address
  sequence s_read(a);
    rd_i && addr_i == a;
  endsequence
  a_read_lane8: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_read(8'h25) |=> rd_data_o == {2'h0, $past(sh_tx)})
    else $error("lane 8 register read wrong");
  a_read_capture: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_read(8'h26) |=> rd_data_o == $past(sh_cap))
    else $error("capture register read wrong");
  a_read_pinsel: assert property (
    @(posedge clk_i) disable iff (reset_i)
    s_read(8'h27) |=> rd_data_o == $past(sh_sel))
    else $error("pin select register read wrong");
  a_read_idle: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    @(posedge clk_i) disable iff (reset_i)
    rd_i && !(addr_i inside {8'h25, 8'h26, 8'h27, 8'h30})
    |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_lane_undriven: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    quiet && !sh_tx[5] |-> !tx_lane8_oe_o)
    else $error("lane 8 driven while its source is off");
  a_lane_data: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    tx_lane8_oe_o |-> tx_lane8_data_o == shared_link_data_i)
    else $error("lane 8 data not the shared stream");
  a_pin_map: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    quiet && rx_valid_o |-> (rx_lane_bits_o ^ sh_sel) inside {8'h00, 8'hFF})
    else $error("lane bits not taken from the selected pin");
  a_valid_pulse: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    rx_valid_o |=> !rx_valid_o)
    else $error("capture pulse longer than one cycle");
  a_bit_bound: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    rx_valid_o |-> rx_bit_o < slot_width_i)
    else $error("bit index beyond slot width");
endmodule : aprx_chk

bind aprx_top aprx_chk u_chk
(
  .clk_i, .reset_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
  .slot_width_i, .link_clk_i, .shared_link_data_i, .tx_lane8_data_o,
  .tx_lane8_oe_o, .rx_valid_o, .rx_lane_bits_o, .rx_bit_o
);

// file: testbench/tb_aprx_top.sv
`timescale 1ns/100ps
// ----------------
// bench for register and capture behaviour
// ----------------
module tb_aprx_top;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] x;} aprx_rrow_t;
  typedef struct {
    logic [7:0] cap; logic [7:0] sel; logic pol; logic ctrl;
    int cnt; logic [7:0] bits;
  } aprx_lrow_t;
  logic clk_i, reset_i, wr_i, rd_i, link_clk_i, host_en;
  logic [7:0] addr_i, wr_data_i, rd_data_o, rx_lane_bits_o, v;
  logic pol, ctrl, ebc, efr, pri, sec, tx_d, tx_oe, rx_valid_o;
  logic [1:0] fmt_i;
  logic [4:0] rx_slot_o;
  logic [5:0] rx_bit_o, lbit;
  logic [4:0] lslot, off;
  logic hi_seen, oe_seen, oe_bad, counting;
  int n_errors = 0, check_count = 0, vcnt = 0, cyc = 0;
  // register rows: address, written value, value read back
  aprx_rrow_t rrows [7] = '{'{8'h25, 8'h3F, 8'h3F}, '{8'h25, 8'h25, 8'h25},
    '{8'h26, 8'hA5, 8'hA5}, '{8'h27, 8'h5A, 8'h5A}, '{8'h27, 8'h81, 8'h81},
    '{8'h31, 8'hFF, 8'h00}, '{8'h24, 8'hFF, 8'h00}};
  // capture rows: capture setting, pin select, polarity, controller mode,
  // captures expected in one frame, lane bits of the last capture
  aprx_lrow_t lrows [8] = '{'{8'h00, 8'h0F, 0, 0, 48, 8'hF0},
    '{8'h05, 8'h00, 0, 0, 43, 8'hFF}, '{8'h80, 8'h00, 0, 0, 48, 8'h00},
    '{8'h00, 8'h00, 1, 0, 48, 8'h00}, '{8'h80, 8'h00, 1, 0, 48, 8'hFF},
    '{8'h20, 8'h00, 0, 1, 0, 8'h00}, '{8'h40, 8'h00, 0, 1, 0, 8'h00},
    '{8'h60, 8'h00, 0, 0, 48, 8'hFF}};
  aprx_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .bitclk_polarity_cfg_i(pol), .ctrl_mode_i(ctrl), .fmt_i(fmt_i),
    .slot_width_i(6'h10), .link_clk_i(link_clk_i), .ext_bitclk_i(ebc),
    .int_bitclk_i(1'b0), .ext_frame_i(efr), .int_frame_i(1'b0),
    .primary_data_in_i(pri), .secondary_data_in_i(sec),
    .shared_link_data_i(1'b1), .tx_lane8_data_o(tx_d),
    .tx_lane8_oe_o(tx_oe), .rx_valid_o(rx_valid_o),
    .rx_lane_bits_o(rx_lane_bits_o), .rx_slot_o(rx_slot_o),
    .rx_bit_o(rx_bit_o));
  aprx_far_host host (.en_i(host_en), .i2s_i(fmt_i != 2'h0), .bitclk_o(ebc),
    .frame_o(efr), .pri_o(pri), .sec_o(sec));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // link clock offset so its edges never meet the host's pin changes
  initial
  begin
    link_clk_i = 1'b0;
    #3.7;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  // record the last capture and lane 8 activity in the link domain
  always @(posedge link_clk_i)
  begin
    if (counting === 1'b1 && rx_valid_o === 1'b1)
    begin
      vcnt = vcnt + 1;
      lslot = rx_slot_o;
      lbit = rx_bit_o;
      v = rx_lane_bits_o;
      if (rx_slot_o >= 5'h10)
        hi_seen = 1'b1;
    end
    if (counting === 1'b1 && tx_oe === 1'b1)
    begin
      oe_seen = 1'b1;
      if (tx_d !== 1'b1)
        oe_bad = 1'b1;
    end
  end
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      conclude();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rst;
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
  endtask : rst
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
  endtask : wr
  // data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask : rd
  task idle;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : idle
  // one whole frame between two frame edges, after the settings cross
  task window;
    repeat (10) @(posedge clk_i);
    host_en <= 1'b1;
    @(posedge efr);
    vcnt = 0;
    hi_seen = 1'b0;
    oe_seen = 1'b0;
    oe_bad = 1'b0;
    counting = 1'b1;
    @(posedge efr);
    // the last capture of the frame is recorded by now, the first one of
    // the next frame not yet, for either capture edge
    #80;
    counting = 1'b0;
    @(posedge clk_i);
    host_en <= 1'b0;
  endtask : window
  task conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial
  begin
    // reset stands from time zero so no check sees unknown state
    {reset_i, wr_i, rd_i, host_en, pol, ctrl} = 6'h20;
    {addr_i, wr_data_i, fmt_i} = 18'h00000;
    rst();
    foreach (rrows[i])
    begin
      wr(rrows[i].a, rrows[i].d);
      rd(rrows[i].a, v);
      chk(v, rrows[i].x);
    end
    $display("test register rows done");
    rst();
    rd(8'h25, v);
    chk(v, 8'h07);
    rd(8'h26, v);
    chk(v, 8'h00);
    rd(8'h27, v);
    chk(v, 8'h00);
    $display("test reset values done");
    foreach (lrows[i])
    begin
      rst();
      pol <= lrows[i].pol;
      ctrl <= lrows[i].ctrl;
      fmt_i <= 2'h0;
      wr(8'h26, lrows[i].cap);
      wr(8'h27, lrows[i].sel);
      idle();
      window();
      off = lrows[i].cap[4:0];
      if (lrows[i].cnt >= 0)
        chk(8'(vcnt), 8'(lrows[i].cnt));
      if (lrows[i].cnt != 0)
        chk(v, lrows[i].bits);
      if (lrows[i].cnt > 0)
      begin
        chk({3'h0, lslot}, 8'((47 - off) / 16));
        chk({2'h0, lbit}, 8'((47 - off) % 16));
      end
      $display("test capture row %0d done", i);
    end
    rst();
    fmt_i <= 2'h1;
    window();
    chk(8'(vcnt), 8'd46);
    chk({7'h0, hi_seen}, 8'h01);
    $display("test two-half frame done");
    rst();
    fmt_i <= 2'h2;
    window();
    chk(8'(vcnt), 8'h30);
    chk({3'h0, lslot}, 8'h11);
    chk({2'h0, lbit}, 8'h07);
    $display("test left-justified frame done");
    rst();
    fmt_i <= 2'h0;
    window();
    chk({7'h0, oe_seen}, 8'h00);
    wr(8'h25, 8'h21);
    idle();
    window();
    chk({7'h0, oe_seen}, 8'h01);
    chk({7'h0, oe_bad}, 8'h00);
    $display("test lane 8 done");
    conclude();
  end
endmodule : tb_aprx_top
